/* fifo_irq_pkg.sv */
// package: constants, register map and carrier types of the buffer interrupt block
package fifo_irq_pkg;
  localparam int DEPTH = 256;
  localparam int CNT_W = 9;
  localparam int WM_W = 8;
  localparam int LIM_W = 12;
  localparam int HYST = 2;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_IO = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  // control register field positions
  localparam int CTRL_WM_LSB = 0;
  localparam int CTRL_WM_IE = 8;
  localparam int CTRL_EMPTY_IE = 9;
  localparam int CTRL_OVR_IE = 10;
  localparam int CTRL_LOW_IE = 11;
  localparam int CTRL_HIGH_IE = 12;
  localparam int CTRL_RERR_IE = 13;
  localparam int CTRL_WERR_IE = 14;
  localparam int CTRL_FIFO_EN = 15;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0100;
  // limit register: lower value in [11:0], upper in [27:16]
  localparam int LIM_LOW_LSB = 0;
  localparam int LIM_HIGH_LSB = 16;
  localparam logic [31:0] LIMIT_RESET = 32'h0000_0000;
  // io control fields
  localparam int IO_PINSEL_LSB = 0;
  localparam int IO_OUT0_CTL = 2;
  localparam int IO_PINCLR_EN = 3;
  localparam logic [31:0] IO_RESET = 32'h0000_0000;
  // pin selection codes
  localparam logic [1:0] PIN_NONE = 2'h0;
  localparam logic [1:0] PIN_CLK = 2'h1;
  localparam logic [1:0] PIN_OUT0 = 2'h2;
  localparam logic [1:0] PIN_NONE2 = 2'h3;

  // buffer events from the storage logic
  typedef struct packed {
    logic wr;
    logic rd_last;
    logic rd_empty;
    logic lost;
    logic wr_err;
    logic rd_err;
    logic rd_ok;
    logic drained;
  } fifo_evt_t;

  // status flags: error and overrun sticky; watermark follows the fill count, limit flags release with hysteresis, empty follows reads and writes
  typedef struct packed {
    logic wr_err;
    logic rd_err;
    logic upper;
    logic lower;
    logic overrun;
    logic watermark;
    logic empty;
  } fifo_flags_t;
endpackage

/* limit_check.sv */
// upper and lower limit flags with hysteresis on a 12-bit result
`timescale 1ns/100ps
module limit_check #(
  parameter int W = fifo_irq_pkg::LIM_W
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic sample_vld,
  input wire logic [W-1:0] sample,
  input wire logic [W-1:0] upper_limit_value,
  input wire logic [W-1:0] lower_limit_value,
  output logic upper_limit_flag,
  output logic lower_limit_flag
);
  import fifo_irq_pkg::*;

  logic upper_ff;
  logic lower_ff;
  logic [W+1:0] s_ext;
  logic [W+1:0] hi_ext;
  logic [W+1:0] lo_ext;

  // widen to avoid wrap in the hysteresis sums
  assign s_ext = {2'b00, sample};
  assign hi_ext = {2'b00, upper_limit_value};
  assign lo_ext = {2'b00, lower_limit_value};

  ////////////////////////////////////////////////////////////////////////
  // flags: sticky while crossing persists, released two codes inside
  always_ff @(posedge clk_sys) begin
    if (sys_rst || clear) begin
      upper_ff <= 1'b0;
      lower_ff <= 1'b0;
    end else if (sample_vld) begin
      if (s_ext > hi_ext)
        upper_ff <= 1'b1;
      else if (s_ext + (W+2)'(HYST) <= hi_ext)
        upper_ff <= 1'b0;
      if (s_ext < lo_ext)
        lower_ff <= 1'b1;
      else if (s_ext >= lo_ext + (W+2)'(HYST))
        lower_ff <= 1'b0;
    end
  end

  assign upper_limit_flag = upper_ff;
  assign lower_limit_flag = lower_ff;
endmodule

/* fifo_irq_ctrl.sv */
// buffer interrupt generation, pin routing and buffer clear control
`timescale 1ns/100ps
module fifo_irq_ctrl #(
  parameter int DEPTH = fifo_irq_pkg::DEPTH
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // buffer storage side
  input wire logic [fifo_irq_pkg::CNT_W-1:0] fill_count,
  input wire fifo_irq_pkg::fifo_evt_t evt,
  input wire logic [23:0] result,
  input wire logic standby,
  input wire logic clk_src_ext,
  input wire logic sync_n,
  output logic buf_clear,
  output logic seq_restart,
  output fifo_irq_pkg::fifo_flags_t flags,
  // pins
  output logic clk_pin_out,
  output logic clk_pin_oe,
  output logic clk_ext_use,
  output logic general_output_zero,
  output logic general_output_pins_on,
  output logic irq
);
  import fifo_irq_pkg::*;

  logic [31:0] ctrl_ff;
  logic [31:0] limit_ff;
  logic [31:0] io_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic sync_m_ff;
  logic sync_s_ff;
  logic sync_d_ff;
  logic clear_ff;
  logic restart_ff;
  logic empty_ff;
  logic ovr_ff;
  logic werr_ff;
  logic rerr_ff;
  logic irq_ff;
  logic clk_out_ff;
  logic clk_oe_ff;
  logic clk_use_ff;
  logic out0_ff;
  logic gpo_on_ff;
  logic nxt_irq;
  logic wr_ctrl;
  logic sync_clr;
  logic clear_now;
  logic wm_hit;
  logic wm_ff;
  logic upper_flag;
  logic lower_flag;
  logic [1:0] pin_sel;
  logic [CNT_W-1:0] level;

  // turn the watermark field into a trigger level
  function automatic logic [CNT_W-1:0] wm_level(input logic [WM_W-1:0] f);
    if (f == '0)
      wm_level = CNT_W'(DEPTH);
    else
      wm_level = {1'b0, f};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait-free access phase, unmapped gives an error
  assign wr_ctrl = psel && penable && pwrite && paddr == ADDR_CTRL;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_ff <= CTRL_RESET;
      limit_ff <= LIMIT_RESET;
      io_ff <= IO_RESET;
    end else if (psel && penable && pwrite) begin
      unique case (paddr)
        ADDR_CTRL: ctrl_ff <= pwdata & 32'h0000_FFFF;
        ADDR_LIMIT: limit_ff <= pwdata & 32'h0FFF_0FFF;
        ADDR_IO: io_ff <= pwdata & 32'h0000_000F;
        default: ;
      endcase
    end
  end

  // read data, ready and error answer
  // read data is latched in setup so it stands through the access phase
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= psel && !penable;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      if (psel && !penable) begin
        unique case (paddr)
          ADDR_CTRL: prdata_ff <= ctrl_ff;
          ADDR_LIMIT: prdata_ff <= limit_ff;
          ADDR_IO: prdata_ff <= io_ff;
          ADDR_STATUS: prdata_ff <= {25'h0, flags};
          default: pslverr_ff <= 1'b1;
        endcase
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  ////////////////////////////////////////////////////////////////////////
  // sync pin: two-stage synchroniser then falling-edge detect
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync_m_ff <= 1'b1;
      sync_s_ff <= 1'b1;
      sync_d_ff <= 1'b1;
    end else begin
      sync_m_ff <= sync_n;
      sync_s_ff <= sync_m_ff;
      sync_d_ff <= sync_s_ff;
    end
  end

  // an edge, not a level: a pin held low clears the buffer only once
  assign sync_clr = io_ff[IO_PINCLR_EN] && sync_d_ff && !sync_s_ff;
  assign clear_now = (wr_ctrl && ctrl_ff[CTRL_FIFO_EN]) || sync_clr;

  // clear and sequencer restart pulses
  // only the pin path restarts the sequencer; register writes leave it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      clear_ff <= 1'b0;
      restart_ff <= 1'b0;
    end else begin
      clear_ff <= clear_now;
      restart_ff <= sync_clr;
    end
  end

  assign buf_clear = clear_ff;
  assign seq_restart = restart_ff;

  ////////////////////////////////////////////////////////////////////////
  // status flags; set wins over clear in the same cycle, except the limit flags, where clear or drain wins over a sample
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      empty_ff <= 1'b1;
    end else if (evt.rd_last || evt.rd_empty) begin
      empty_ff <= 1'b1;
    end else if (evt.wr || clear_ff) begin
      empty_ff <= clear_ff;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ovr_ff <= 1'b0;
    end else if (evt.lost) begin
      ovr_ff <= 1'b1;
    end else if (evt.drained || clear_ff) begin
      ovr_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      werr_ff <= 1'b0;
      rerr_ff <= 1'b0;
    end else begin
      if (evt.wr_err)
        werr_ff <= 1'b1;
      else if (evt.drained || clear_ff)
        werr_ff <= 1'b0;
      if (evt.rd_err)
        rerr_ff <= 1'b1;
      else if (evt.rd_ok || evt.drained || clear_ff)
        rerr_ff <= 1'b0;
    end
  end

  assign level = wm_level(ctrl_ff[CTRL_WM_LSB +: WM_W]);
  assign wm_hit = fill_count >= level;

  // registered watermark, so every status bit leaves the block from a flop;
  // it follows the count both ways, one cycle behind
  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      wm_ff <= 1'b0;
    else
      wm_ff <= wm_hit;
  end

  // limit flags with two-code hysteresis, also released on drain or clear
  limit_check #(
    .W(LIM_W)
  ) u_limit (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clear(clear_ff || evt.drained),
    .sample_vld(evt.wr),
    .sample(result[23:12]),
    .upper_limit_value(limit_ff[LIM_HIGH_LSB +: LIM_W]),
    .lower_limit_value(limit_ff[LIM_LOW_LSB +: LIM_W]),
    .upper_limit_flag(upper_flag),
    .lower_limit_flag(lower_flag)
  );

  assign flags = '{wr_err: werr_ff, rd_err: rerr_ff, upper: upper_flag,
                   lower: lower_flag, overrun: ovr_ff, watermark: wm_ff,
                   empty: empty_ff};

  ////////////////////////////////////////////////////////////////////////
  // combined interrupt
  assign pin_sel = io_ff[IO_PINSEL_LSB +: 2];

  always_comb begin
    nxt_irq = (ctrl_ff[CTRL_WM_IE] && wm_ff)
      || (ctrl_ff[CTRL_HIGH_IE] && upper_flag)
      || (ctrl_ff[CTRL_LOW_IE] && lower_flag)
      || (ctrl_ff[CTRL_EMPTY_IE] && empty_ff)
      || (ctrl_ff[CTRL_WERR_IE] && werr_ff)
      || (ctrl_ff[CTRL_RERR_IE] && rerr_ff)
      || (ctrl_ff[CTRL_OVR_IE] && ovr_ff);
    if (pin_sel == PIN_NONE || pin_sel == PIN_NONE2)
      nxt_irq = 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      irq_ff <= 1'b0;
    else
      irq_ff <= nxt_irq;
  end

  assign irq = irq_ff;

  ////////////////////////////////////////////////////////////////////////
  // pin routing: interrupt takes priority over other pin uses
  // pins take the next interrupt value so they move together with irq
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      clk_out_ff <= 1'b0;
      clk_oe_ff <= 1'b0;
      clk_use_ff <= 1'b0;
      out0_ff <= 1'b0;
      gpo_on_ff <= 1'b1;
    end else begin
      clk_oe_ff <= pin_sel == PIN_CLK;
      clk_out_ff <= pin_sel == PIN_CLK && nxt_irq;
      clk_use_ff <= clk_src_ext && pin_sel != PIN_CLK;
      if (pin_sel == PIN_OUT0)
        out0_ff <= nxt_irq;
      else
        out0_ff <= io_ff[IO_OUT0_CTL];
      gpo_on_ff <= !standby || pin_sel == PIN_OUT0;
    end
  end

  assign clk_pin_out = clk_out_ff;
  assign clk_pin_oe = clk_oe_ff;
  assign clk_ext_use = clk_use_ff;
  assign general_output_zero = out0_ff;
  assign general_output_pins_on = gpo_on_ff;
endmodule

/* fifo_irq_chk.sv */
// checker: port-level assertions for the buffer interrupt block
`timescale 1ns/100ps
module fifo_irq_chk (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire fifo_irq_pkg::fifo_evt_t evt,
  input wire fifo_irq_pkg::fifo_flags_t flags,
  input wire logic standby,
  input wire logic buf_clear,
  input wire logic seq_restart,
  input wire logic clk_pin_oe,
  input wire logic clk_ext_use,
  input wire logic general_output_pins_on
);
  import fifo_irq_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  a_clk_pin_wins: assert property (clk_pin_oe |-> !clk_ext_use)
    else $error("clock pin taken as input");
  a_restart_clear: assert property (seq_restart |-> buf_clear)
    else $error("restart without clear");
  a_empty_on_wr: assert property (evt.wr && !evt.rd_last && !evt.rd_empty
    && !buf_clear |=> !flags.empty)
    else $error("empty kept after write");
  a_empty_on_rd: assert property (evt.rd_empty |=> flags.empty)
    else $error("empty not set");
  a_ovr_set: assert property (evt.lost |=> flags.overrun)
    else $error("overrun not set");
  a_drain_clr: assert property (evt.drained && !evt.lost && !evt.wr_err
    |=> !flags.overrun && !flags.wr_err)
    else $error("drain left errors");
  a_clear_limits: assert property (buf_clear && !evt.wr
    |=> !flags.upper && !flags.lower)
    else $error("limit flags kept");
  a_gpo_standby: assert property (!standby |=> general_output_pins_on)
    else $error("outputs off outside standby");
  a_werr_set: assert property (evt.wr_err |=> flags.wr_err)
    else $error("write error not set");
endmodule
bind fifo_irq_ctrl fifo_irq_chk chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .evt(evt), .flags(flags), .standby(standby), .buf_clear(buf_clear),
  .seq_restart(seq_restart), .clk_pin_oe(clk_pin_oe),
  .clk_ext_use(clk_ext_use),
  .general_output_pins_on(general_output_pins_on));

/* host_mcu.sv */
// host model: drives the active-low sync pin, pulled up when idle
`timescale 1ns/100ps
module host_mcu (
  input wire logic clk_sys,
  input wire logic clr_req,
  output logic sync_n
);
  int low_cnt = 0;
  // hold the pin low four cycles per request
  always @(posedge clk_sys) begin
    if (clr_req) low_cnt <= 4;
    else if (low_cnt > 0) low_cnt <= low_cnt - 1;
  end
  assign sync_n = (low_cnt == 0);
endmodule

/* test_fifo_interrupt_and_clear_logic.sv */
// testbench: register, interrupt, pin routing and clear scenarios
`timescale 1ns/100ps
module test_fifo_interrupt_and_clear_logic;
  import fifo_irq_pkg::*;
  logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, rs;
  logic [31:0] pwdata, prdata, q, ctl_m, io_m;
  logic [8:0] fill_count;
  logic [23:0] result;
  logic standby, clk_src_ext, sync_n, buf_clear, seq_restart, clr_req;
  logic clk_pin_out, clk_pin_oe, clk_ext_use, general_output_zero, irq;
  logic general_output_pins_on;
  logic [6:0] fl_m;
  fifo_evt_t evt;
  fifo_flags_t flags;
  int fill_m, num_errors, n_tests, w;
  int ie[4] = '{9, 10, 13, 14};
  int sb[4] = '{5, 4, 2, 3};
  int cb[4] = '{7, 0, 1, 0};
  logic [31:0] rv[4] = '{CTRL_RESET, LIMIT_RESET, IO_RESET, 32'h1};
  fifo_irq_ctrl uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fill_count(fill_count), .evt(evt), .result(result),
    .standby(standby), .clk_src_ext(clk_src_ext), .sync_n(sync_n),
    .buf_clear(buf_clear), .seq_restart(seq_restart), .flags(flags),
    .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe),
    .clk_ext_use(clk_ext_use), .general_output_zero(general_output_zero),
    .general_output_pins_on(general_output_pins_on), .irq(irq));
  host_mcu host (.clk_sys(clk_sys), .clr_req(clr_req), .sync_n(sync_n));
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int k;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      num_errors++;
      complete_run();
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1, a, d);
    if (a == ADDR_CTRL) ctl_m = d;
    if (a == ADDR_IO) io_m = d;
  endtask
  task automatic fill(int n);
    fill_m = n;
    fill_count <= 9'(n);
  endtask
  // one event pulse and its effect on the model flags
  task automatic ev(int b);
    evt <= fifo_evt_t'(8'h01 << b);
    @(posedge clk_sys);
    evt <= '0;
    @(posedge clk_sys);
    case (b)
      7: fl_m[0] = 0;
      6, 5: fl_m[0] = 1;
      4: fl_m[2] = 1;
      3: fl_m[6] = 1;
      2: fl_m[5] = 1;
      1: fl_m[5] = 0;
      default: fl_m[6:2] = 0;
    endcase
  endtask
  task automatic smp(int r);
    result <= 24'(r << 12);
    ev(7);
    if (r > 200) fl_m[4] = 1;
    else if (r + HYST <= 200) fl_m[4] = 0;
    if (r < 100) fl_m[3] = 1;
    else if (r >= 100 + HYST) fl_m[3] = 0;
  endtask
  function automatic logic [7:0] lfsr(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [6:0] fexp();
    logic wm;
    wm = fill_m >= (ctl_m[7:0] == 0 ? 256 : int'(ctl_m[7:0]));
    return {fl_m[6:2], wm, fl_m[0]};
  endfunction
  function automatic logic exp_irq();
    logic [6:0] m;
    m = {ctl_m[14:10], ctl_m[8], ctl_m[9]};
    return (|(fexp() & m)) && io_m[0] != io_m[1];
  endfunction
  // compare all pin and flag outputs with the model
  task automatic look();
    logic x;
    repeat (3) @(posedge clk_sys);
    x = exp_irq();
    chk("irq", x, irq);
    chk("flags", fexp(), flags);
    chk("oe", io_m[1:0] == 1, clk_pin_oe);
    chk("clkout", io_m[1:0] == 1 && x, clk_pin_out);
    chk("out0", io_m[1:0] == 2 ? x : io_m[2], general_output_zero);
    chk("ext", clk_src_ext && io_m[1:0] != 1, clk_ext_use);
    chk("gpo", !standby || io_m[1:0] == 2, general_output_pins_on);
  endtask
  task automatic waitclr(logic s);
    logic b, r;
    b = 0;
    r = 0;
    repeat (12) begin
      b |= buf_clear;
      r |= seq_restart;
      @(posedge clk_sys);
    end
    chk("clear", 1, b);
    chk("restart", s, r);
    fl_m[6:2] = 0;
    fl_m[0] = 1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, standby, clr_req} = '0;
    paddr = 0;
    pwdata = 0;
    evt = '0;
    result = 0;
    fill_count = 0;
    clk_src_ext = 1;
    sys_rst = 1;
    {num_errors, n_tests, fill_m} = '0;
    {ctl_m, io_m, fl_m, rs} = {CTRL_RESET, IO_RESET, 7'h01, 8'h22};
    repeat (3) @(posedge clk_sys);
    sys_rst <= 0;
    for (int i = 0; i < 4; i++) begin
      apb(0, 8'(4 * i), 0);
      chk("reset", rv[i], q);
    end
    apb(0, 8'h10, 0);
    chk("slverr", 1, e);
    wr(ADDR_IO, 32'h1);
    fill(255);
    look();
    fill(256);
    look();
    rs = lfsr(rs);
    w = int'(rs | 8'h01);
    wr(ADDR_CTRL, 32'h100 | w);
    fill(w);
    look();
    fill(w - 1);
    look();
    wr(ADDR_CTRL, w);
    fill(w);
    look();
    fill(0);
    wr(ADDR_LIMIT, 32'h00C8_0064);
    wr(ADDR_CTRL, 32'h1800);
    smp(200);
    smp(100);
    look();
    smp(201);
    smp(199);
    look();
    smp(99);
    smp(101);
    look();
    wr(ADDR_CTRL, 32'h9800);
    wr(ADDR_CTRL, 32'h9800);
    waitclr(0);
    look();
    apb(0, ADDR_STATUS, 0);
    chk("status", fexp(), q);
    wr(ADDR_IO, 32'h9);
    ev(4);
    look();
    clr_req <= 1;
    @(posedge clk_sys);
    clr_req <= 0;
    waitclr(1);
    look();
    wr(ADDR_CTRL, 0);
    waitclr(0);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL, 32'h1 << ie[i]);
      ev(7);
      look();
      ev(sb[i]);
      look();
      ev(cb[i]);
      look();
    end
    wr(ADDR_CTRL, 32'h100);
    fill(256);
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_IO, (p == 2 ? 32'h0 : 32'h4) | p);
      look();
      standby <= 1;
      look();
      standby <= 0;
    end
    complete_run();
  end
endmodule
